// file: hbp_pkg.sv
// Shared constants and types for the host bus read path
package hbp_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BURST_MAX = 16;
    localparam int RX_FIFO_DEPTH = 8;

    localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_RX_STATUS = 9'h020;
    localparam logic [ADDR_W-1:0] ADDR_TX_STATUS = 9'h024;
    localparam logic [ADDR_W-1:0] ADDR_BYTE_ORDER_PROBE = 9'h032;
    localparam logic [ADDR_W-1:0] ADDR_RX_FIFO_LEVEL = 9'h03e;
    localparam logic [ADDR_W-1:0] ADDR_TX_FIFO_LEVEL = 9'h040;
    localparam logic [ADDR_W-1:0] ADDR_DROP_COUNT = 9'h050;
    localparam logic [ADDR_W-1:0] ADDR_FABRIC_DATA = 9'h058;
    localparam logic [ADDR_W-1:0] ADDR_FABRIC_COMMAND = 9'h05a;
    localparam logic [ADDR_W-1:0] ADDR_AUTONEG_EXPANSION = 9'h060;

    // Arbitrary pattern; lets software see the byte order it chose
    localparam logic [DATA_W-1:0] BYTE_ORDER_PATTERN = 16'h4321;
    localparam logic [DATA_W-1:0] UNMAPPED_WORD = 16'h0000;

    localparam int WAIT_WRITE_NS = 45;
    localparam int WAIT_LEVEL_NS = 135;
    localparam int WAIT_DROP_NS = 180;
    localparam int WAIT_FABRIC_NS = 45;
    localparam int WAIT_AUTONEG_NS = 45;
    localparam int SIDE_EFFECT_NS = 90;
    localparam int WAIT_WRITE_CYC = (WAIT_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_LEVEL_CYC = (WAIT_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_DROP_CYC = (WAIT_DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_FABRIC_CYC = (WAIT_FABRIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_AUTONEG_CYC = (WAIT_AUTONEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SIDE_EFFECT_CYC = SIDE_EFFECT_NS / CLK_PERIOD_NS;

    localparam int HOST_GAP_CYC = 4;
    localparam int HOST_DATA_CYC = 8;

    typedef enum logic [1:0] {
        DEV_IDLE   = 2'b01,
        DEV_ACTIVE = 2'b10
    } hbp_dev_state_type;

    typedef enum logic [3:0] {
        HST_IDLE   = 4'b0001,
        HST_WAIT   = 4'b0010,
        HST_SETUP  = 4'b0100,
        HST_STROBE = 4'b1000
    } hbp_host_state_type;
endpackage : hbp_pkg

// file: hbp_bus_if.sv
// Host bus pins joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface hbp_bus_if import hbp_pkg::*; ();
    logic              hostSelectN;
    logic              readStrobeN;
    logic              byteOrderSel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              dataOe;

    modport device (
        input  hostSelectN,
        input  readStrobeN,
        input  byteOrderSel,
        input  addr,
        output data,
        output dataOe
    );

    modport host (
        output hostSelectN,
        output readStrobeN,
        output byteOrderSel,
        output addr,
        input  data,
        input  dataOe
    );
endinterface : hbp_bus_if
`default_nettype wire

// file: hbp_device.sv
// Device end of the host bus read path, with its receive data FIFO
// Operation
// - Host waits after writes before reading
// - Side effects of reads show later
// - Wait before reading FIFO level registers
// - Wait between two drop counter reads
// - Wait before fabric command after data
// - Wait between two autoneg expansion reads
// - Dummy read counts assume 45ns cycles
// - Waits may be met by time alone
// - Single reads reach registers and FIFOs
// - Cycle starts when select and strobe low
// - Cycle ends when either deasserts
// - Host keeps a gap between reads
// - Byte order sampled like the address
// - Data driven only inside read window
// - Bursts carry up to 16 words
// - Each A1 toggle gives fresh word
// - Bursts only from receive data FIFO
// - Burst ends on deassert, then gap
// - Byte order timed like upper address
// - Fabric direct window needs no wait
`timescale 1ns/1ps
`default_nettype none
module hbp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             wrValid,
    input  wire logic [WIDTH-1:0] wrData,
    output logic                  wrReady,
    output logic                  rdValid,
    output logic [WIDTH-1:0]      rdData,
    input  wire logic             rdReady,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_depth
        $error("hbp_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0]   count;
        logic          notFull;
    } hbp_fifo_state_type;

    hbp_fifo_state_type fifo_reg;
    hbp_fifo_state_type fifo_next;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic               doWrite;
    logic               doRead;

    always_comb begin
        doWrite = wrValid && fifo_reg.notFull;
        doRead = rdReady && (fifo_reg.count != '0);
        fifo_next = fifo_reg;
        if (doWrite) begin
            fifo_next.wrPtr = fifo_reg.wrPtr + 1'b1;
        end
        if (doRead) begin
            fifo_next.rdPtr = fifo_reg.rdPtr + 1'b1;
        end
        fifo_next.count = fifo_reg.count + (PW+1)'(doWrite)
                          - (PW+1)'(doRead);
        // Registered so the source sees ready straight from a flop
        fifo_next.notFull = fifo_next.count != (PW+1)'(DEPTH);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fifo_reg <= '{wrPtr: '0, rdPtr: '0, count: '0, notFull: 1'b1};
        end else begin
            fifo_reg <= fifo_next;
        end
        if (doWrite) begin
            mem[fifo_reg.wrPtr] <= wrData;
        end
    end

    assign wrReady = fifo_reg.notFull;
    assign rdValid = fifo_reg.count != '0;
    assign rdData = mem[fifo_reg.rdPtr];
    assign level = fifo_reg.count;
endmodule : hbp_fifo

module hbp_device import hbp_pkg::*; #(
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    input  wire logic              core_clk,
    input  wire logic              srst,
    hbp_bus_if.device              bus,
    input  wire logic              rxWrValid,
    input  wire logic [DATA_W-1:0] rxWrData,
    output logic                   rxWrReady,
    input  wire logic [DATA_W-1:0] rxStatusWord,
    input  wire logic              rxStatusValid,
    output logic                   rxStatusPop,
    input  wire logic [DATA_W-1:0] txStatusWord,
    input  wire logic              txStatusValid,
    output logic                   txStatusPop,
    input  wire logic              dropPulse
);
    localparam int PIN_W = ADDR_W + 3;
    localparam int SEL_BIT = ADDR_W + 2;
    localparam int RD_BIT = ADDR_W + 1;
    localparam int END_BIT = ADDR_W;
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    if (SIDE_EFFECT_CYC < 1 || SIDE_EFFECT_CYC > 15) begin : g_bad_delay
        $error("hbp_device: side effect delay out of range");
    end

    typedef struct packed {
        logic [PIN_W-1:0]  pinSync1;
        logic [PIN_W-1:0]  pinSync2;
        logic [PIN_W-1:0]  pinSync3;
        logic [PIN_W-1:0]  pinStable;
        hbp_dev_state_type state;
        logic [ADDR_W-1:0] addr;
        logic              swap;
        logic              lastA1;
        logic [4:0]        burstCount;
        logic [DATA_W-1:0] dataOut;
        logic              dataOe;
        logic              rxStatusPop;
        logic              txStatusPop;
        logic [3:0]        delay;
        logic              pending;
        logic              dropClear;
        logic [DATA_W-1:0] dropCount;
        logic [DATA_W-1:0] rxLevelShown;
        logic [DATA_W-1:0] txLevelShown;
    } hbp_dev_regs_type;

    hbp_dev_regs_type  dev_reg;
    hbp_dev_regs_type  dev_next;
    logic              fifoValid;
    logic [DATA_W-1:0] fifoWord;
    logic              fifoPop;
    logic [LW-1:0]     fifoLevel;
    logic              begun;
    logic [ADDR_W-1:0] pinAddr;
    logic [ADDR_W-1:0] fetchAddr;
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] shown;
    logic [DATA_W-1:0] dropBase;

    hbp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
        .core_clk (core_clk),
        .srst     (srst),
        .wrValid  (rxWrValid),
        .wrData   (rxWrData),
        .wrReady  (rxWrReady),
        .rdValid  (fifoValid),
        .rdData   (fifoWord),
        .rdReady  (fifoPop),
        .level    (fifoLevel)
    );

    function automatic logic isRxData(input logic [ADDR_W-1:0] a);
        // A1 is the burst toggle, so it takes no part in the decode
        return a[ADDR_W-1:1] == ADDR_RX_DATA[ADDR_W-1:1];
    endfunction : isRxData

    always_comb begin
        dev_next = dev_reg;
        dev_next.pinSync1 = {bus.hostSelectN, bus.readStrobeN,
                             bus.byteOrderSel, bus.addr};
        dev_next.pinSync2 = dev_reg.pinSync1;
        dev_next.pinSync3 = dev_reg.pinSync2;
        for (int i = 0; i < PIN_W; i++) begin
            if (dev_reg.pinSync2[i] == dev_reg.pinSync3[i]) begin
                dev_next.pinStable[i] = dev_reg.pinSync3[i];
            end
        end
        begun = !dev_reg.pinStable[SEL_BIT] && !dev_reg.pinStable[RD_BIT];
        pinAddr = dev_reg.pinStable[ADDR_W-1:0];
        fetchAddr = (dev_reg.state == DEV_IDLE) ? pinAddr : dev_reg.addr;
        fifoPop = 1'b0;
        dev_next.rxStatusPop = 1'b0;
        dev_next.txStatusPop = 1'b0;

        unique case (fetchAddr)
            ADDR_BYTE_ORDER_PROBE: word = BYTE_ORDER_PATTERN;
            ADDR_RX_STATUS: word = rxStatusValid ? rxStatusWord : '0;
            ADDR_TX_STATUS: word = txStatusValid ? txStatusWord : '0;
            ADDR_RX_FIFO_LEVEL: word = dev_reg.rxLevelShown;
            ADDR_TX_FIFO_LEVEL: word = dev_reg.txLevelShown;
            ADDR_DROP_COUNT: word = dev_reg.dropCount;
            default: word = isRxData(fetchAddr)
                            ? (fifoValid ? fifoWord : UNMAPPED_WORD)
                            : UNMAPPED_WORD;
        endcase
        // Swapped where taken, so a held word is never swapped twice
        shown = (dev_reg.state == DEV_IDLE ? dev_reg.pinStable[END_BIT]
                                            : dev_reg.swap)
                ? {word[7:0], word[15:8]} : word;

        // Dependent values settle only after a delay, as real pipes do
        dropBase = dev_reg.dropCount;
        if (dev_reg.delay != '0) begin
            dev_next.delay = dev_reg.delay - 1'b1;
        end else if (dev_reg.pending) begin
            dev_next.pending = 1'b0;
            dev_next.dropClear = 1'b0;
            dev_next.rxLevelShown = DATA_W'(fifoLevel);
            dev_next.txLevelShown = DATA_W'(txStatusValid);
            if (dev_reg.dropClear) begin
                dropBase = '0;
            end
        end
        // A drop in the clearing cycle is counted, not lost
        dev_next.dropCount = dropBase + DATA_W'(dropPulse);

        unique case (dev_reg.state)
            DEV_IDLE: begin
                dev_next.dataOe = 1'b0;
                dev_next.dataOut = '0;
                if (begun) begin
                    dev_next.state = DEV_ACTIVE;
                    dev_next.addr = pinAddr;
                    dev_next.swap = dev_reg.pinStable[END_BIT];
                    dev_next.lastA1 = pinAddr[0];
                    dev_next.burstCount = 5'd1;
                    dev_next.dataOe = 1'b1;
                    dev_next.dataOut = shown;
                    fifoPop = isRxData(pinAddr) && fifoValid;
                end
            end
            DEV_ACTIVE: begin
                if (!begun) begin
                    dev_next.state = DEV_IDLE;
                    dev_next.dataOe = 1'b0;
                    dev_next.dataOut = '0;
                    if (isRxData(dev_reg.addr)
                        || dev_reg.addr == ADDR_RX_STATUS
                        || dev_reg.addr == ADDR_TX_STATUS
                        || dev_reg.addr == ADDR_DROP_COUNT) begin
                        dev_next.delay = 4'(SIDE_EFFECT_CYC);
                        dev_next.pending = 1'b1;
                    end
                    if (dev_reg.addr == ADDR_DROP_COUNT) begin
                        dev_next.dropClear = 1'b1;
                    end
                    dev_next.rxStatusPop = (dev_reg.addr == ADDR_RX_STATUS)
                                           && rxStatusValid;
                    dev_next.txStatusPop = (dev_reg.addr == ADDR_TX_STATUS)
                                           && txStatusValid;
                end else if (isRxData(dev_reg.addr)
                             && pinAddr[0] != dev_reg.lastA1
                             && dev_reg.burstCount != 5'(BURST_MAX)) begin
                    dev_next.lastA1 = pinAddr[0];
                    dev_next.burstCount = dev_reg.burstCount + 1'b1;
                    dev_next.dataOut = shown;
                    fifoPop = fifoValid;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dev_reg <= '{pinSync1: '1, pinSync2: '1, pinSync3: '1,
                         pinStable: '1, state: DEV_IDLE, addr: '0,
                         swap: 1'b0, lastA1: 1'b0, burstCount: '0,
                         dataOut: '0, dataOe: 1'b0, rxStatusPop: 1'b0,
                         txStatusPop: 1'b0, delay: '0, pending: 1'b0,
                         dropClear: 1'b0, dropCount: '0,
                         rxLevelShown: '0, txLevelShown: '0};
        end else begin
            dev_reg <= dev_next;
        end
    end

    assign bus.data = dev_reg.dataOut;
    assign bus.dataOe = dev_reg.dataOe;
    assign rxStatusPop = dev_reg.rxStatusPop;
    assign txStatusPop = dev_reg.txStatusPop;
endmodule : hbp_device
`default_nettype wire

// file: hbp_host.sv
// Host end of the host bus read path, enforcing read spacing
`timescale 1ns/1ps
`default_nettype none
module hbp_host import hbp_pkg::*; (
    input  wire logic              core_clk,
    input  wire logic              srst,
    hbp_bus_if.host                bus,
    input  wire logic              cmdValid,
    input  wire logic [ADDR_W-1:0] cmdAddr,
    input  wire logic [4:0]        cmdWords,
    input  wire logic              cmdSwap,
    output logic                   cmdReady,
    output logic                   rspValid,
    output logic [DATA_W-1:0]      rspData,
    output logic                   rspLast
);
    typedef struct packed {
        hbp_host_state_type state;
        logic               selN;
        logic               rdN;
        logic               endSel;
        logic [ADDR_W-1:0]  addr;
        logic [ADDR_W-1:0]  lastAddr;
        logic [4:0]         wordsLeft;
        logic [7:0]         timer;
        logic [7:0]         sinceRead;
        logic               cmdReady;
        logic               rspValid;
        logic [DATA_W-1:0]  rspData;
        logic               rspLast;
    } hbp_host_regs_type;

    hbp_host_regs_type host_reg;
    hbp_host_regs_type host_next;
    logic [7:0]        need;

    // No write cycles leave this end, so the post-write wait never arms
    function automatic logic [7:0] waitFor(input logic [ADDR_W-1:0] prev,
                                           input logic [ADDR_W-1:0] next);
        logic [7:0] w;
        w = 8'(HOST_GAP_CYC);
        if (next == ADDR_RX_FIFO_LEVEL && (prev[ADDR_W-1:1]
            == ADDR_RX_DATA[ADDR_W-1:1] || prev == ADDR_RX_STATUS)) begin
            w = 8'(WAIT_LEVEL_CYC);
        end else if (next == ADDR_TX_FIFO_LEVEL
                     && prev == ADDR_TX_STATUS) begin
            w = 8'(WAIT_LEVEL_CYC);
        end else if (next == ADDR_DROP_COUNT && prev == ADDR_DROP_COUNT) begin
            w = 8'(WAIT_DROP_CYC);
        end else if (next == ADDR_FABRIC_COMMAND
                     && prev == ADDR_FABRIC_DATA) begin
            w = 8'(WAIT_FABRIC_CYC);
        end else if (next == ADDR_AUTONEG_EXPANSION
                     && prev == ADDR_AUTONEG_EXPANSION) begin
            w = 8'(WAIT_AUTONEG_CYC);
        end
        return w;
    endfunction : waitFor

    always_comb begin
        host_next = host_reg;
        host_next.rspValid = 1'b0;
        host_next.rspLast = 1'b0;
        need = waitFor(host_reg.lastAddr, host_reg.addr);
        if (host_reg.sinceRead != 8'hff) begin
            host_next.sinceRead = host_reg.sinceRead + 1'b1;
        end
        unique case (host_reg.state)
            HST_IDLE: begin
                if (cmdValid && host_reg.cmdReady) begin
                    host_next.cmdReady = 1'b0;
                    host_next.addr = cmdAddr;
                    host_next.endSel = cmdSwap;
                    // Only the receive data FIFO may be burst
                    if (cmdAddr[ADDR_W-1:1] != ADDR_RX_DATA[ADDR_W-1:1]
                        || cmdWords == '0) begin
                        host_next.wordsLeft = 5'd1;
                    end else if (cmdWords > 5'(BURST_MAX)) begin
                        host_next.wordsLeft = 5'(BURST_MAX);
                    end else begin
                        host_next.wordsLeft = cmdWords;
                    end
                    host_next.state = HST_WAIT;
                end
            end
            HST_WAIT: begin
                if (host_reg.sinceRead >= need) begin
                    host_next.state = HST_SETUP;
                end
            end
            HST_SETUP: begin
                host_next.selN = 1'b0;
                host_next.rdN = 1'b0;
                host_next.timer = 8'(HOST_DATA_CYC);
                host_next.state = HST_STROBE;
            end
            HST_STROBE: begin
                host_next.sinceRead = '0;
                if (host_reg.timer != '0) begin
                    host_next.timer = host_reg.timer - 1'b1;
                end else begin
                    // Data has long settled here, so no synchroniser
                    host_next.rspValid = 1'b1;
                    host_next.rspData = bus.data;
                    if (host_reg.wordsLeft > 5'd1) begin
                        host_next.wordsLeft = host_reg.wordsLeft - 1'b1;
                        host_next.addr[0] = !host_reg.addr[0];
                        host_next.timer = 8'(HOST_DATA_CYC);
                    end else begin
                        host_next.rspLast = 1'b1;
                        host_next.selN = 1'b1;
                        host_next.rdN = 1'b1;
                        host_next.lastAddr = host_reg.addr;
                        host_next.cmdReady = 1'b1;
                        host_next.state = HST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            host_reg <= '{state: HST_IDLE, selN: 1'b1, rdN: 1'b1,
                          endSel: 1'b0, addr: '0, lastAddr: '0,
                          wordsLeft: '0, timer: '0, sinceRead: 8'hff,
                          cmdReady: 1'b1, rspValid: 1'b0, rspData: '0,
                          rspLast: 1'b0};
        end else begin
            host_reg <= host_next;
        end
    end

    assign bus.hostSelectN = host_reg.selN;
    assign bus.readStrobeN = host_reg.rdN;
    assign bus.byteOrderSel = host_reg.endSel;
    assign bus.addr = host_reg.addr;
    assign cmdReady = host_reg.cmdReady;
    assign rspValid = host_reg.rspValid;
    assign rspData = host_reg.rspData;
    assign rspLast = host_reg.rspLast;
endmodule : hbp_host
`default_nettype wire

// file: hbp_bus_monitor.sv
// Protocol checker watching the host bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module hbp_bus_monitor import hbp_pkg::*; (
    input wire logic              core_clk,
    input wire logic              srst,
    input wire logic              hostSelectN,
    input wire logic              readStrobeN,
    input wire logic              byteOrderSel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data,
    input wire logic              dataOe
);
    logic [7:0]        idleCnt_reg;
    logic [ADDR_W-1:0] lastAddr_reg;

    // Idle count saturates so a long pause never wraps into a false short one
    always_ff @(posedge core_clk) begin
        if (srst || !readStrobeN) begin
            idleCnt_reg <= 8'h00;
        end else if (idleCnt_reg != 8'hff) begin
            idleCnt_reg <= idleCnt_reg + 8'h01;
        end
        if (srst) begin
            lastAddr_reg <= '1;
        end else if (!readStrobeN) begin
            lastAddr_reg <= addr;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence cycStart;
        $fell(readStrobeN) && !hostSelectN;
    endsequence
    sequence cycEnd;
        $rose(readStrobeN);
    endsequence
    sequence a1Toggle;
        !readStrobeN && $changed(addr[0]);
    endsequence

    chk_start_answer: assert property (
        cycStart |-> ##[3:6] dataOe) else $error("No data after strobe");
    chk_end_release: assert property (
        cycEnd |-> ##[2:6] !dataOe) else $error("Data held after end");
    chk_idle_quiet: assert property (
        !dataOe |-> data == 16'h0000) else $error("Data outside window");
    chk_host_gap: assert property (
        cycEnd |-> readStrobeN[*4]) else $error("Gap too short");
    chk_addr_steady: assert property (
        !readStrobeN && $past(!readStrobeN) |->
        $stable(byteOrderSel) && $stable(addr[ADDR_W-1:1]))
        else $error("Address moved in cycle");
    chk_burst_rx: assert property (
        a1Toggle |-> addr[ADDR_W-1:1] == 8'h00) else $error("Bad burst");
    chk_burst_fresh: assert property (
        a1Toggle |-> ##[3:6] $changed(data)) else $error("No fresh word");
    chk_level_wait: assert property (
        cycStart and (addr == ADDR_RX_FIFO_LEVEL &&
        (lastAddr_reg[ADDR_W-1:1] == 8'h00 || lastAddr_reg == ADDR_RX_STATUS))
        |-> idleCnt_reg >= WAIT_LEVEL_CYC) else $error("Level read early");
    chk_drop_wait: assert property (
        cycStart and (addr == ADDR_DROP_COUNT
        && lastAddr_reg == ADDR_DROP_COUNT)
        |-> idleCnt_reg >= WAIT_DROP_CYC) else $error("Drop read early");
endmodule : hbp_bus_monitor
`default_nettype wire

// file: tb.sv
// Testbench: host end and device end joined, read traffic checked
`timescale 1ns/1ps
`default_nettype none
module tb import hbp_pkg::*; ;
    logic              core_clk, srst, cmdValid, cmdReady, cmdSwap;
    logic              rspValid, rspLast, rxWrValid, rxWrReady, dropPulse;
    logic              rxStatusValid, txStatusValid, rxStatusPop, txStatusPop;
    logic [ADDR_W-1:0] cmdAddr;
    logic [4:0]        cmdWords;
    logic [DATA_W-1:0] rspData, rxWrData, rxStatusWord, txStatusWord;
    int                n_mismatch, compares;

    hbp_bus_if u_hbp_bus_if ();
    hbp_host u_hbp_host (.core_clk, .srst, .bus(u_hbp_bus_if.host), .cmdValid,
        .cmdAddr, .cmdWords, .cmdSwap, .cmdReady, .rspValid, .rspData,
        .rspLast);
    hbp_device u_hbp_device (.core_clk, .srst, .bus(u_hbp_bus_if.device),
        .rxWrValid, .rxWrData, .rxWrReady, .rxStatusWord, .rxStatusValid,
        .rxStatusPop, .txStatusWord, .txStatusValid, .txStatusPop, .dropPulse);
    hbp_bus_monitor u_hbp_bus_monitor (.core_clk, .srst,
        .hostSelectN(u_hbp_bus_if.hostSelectN),
        .readStrobeN(u_hbp_bus_if.readStrobeN),
        .byteOrderSel(u_hbp_bus_if.byteOrderSel), .addr(u_hbp_bus_if.addr),
        .data(u_hbp_bus_if.data), .dataOe(u_hbp_bus_if.dataOe));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task tick;
        @(posedge core_clk);
        #1;
    endtask : tick

    task chk(input string what, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask : chk

    task conclude;
        $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // One host command; words expected as e0, e0+st, ...
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [4:0] n,
                      input logic sw, input logic [15:0] e0, input logic [15:0] st);
        int k;
        int t;
        k = 0;
        t = 0;
        while (cmdReady !== 1'b1 && t < 200) begin
            tick;
            t++;
        end
        if (t >= 200) begin
            n_mismatch++;
            $display("ERROR cmdReady expected 1 seen %b", cmdReady);
            conclude;
        end
        cmdValid = 1'b1;
        cmdAddr = a;
        cmdWords = n;
        cmdSwap = sw;
        tick;
        cmdValid = 1'b0;
        while (k < int'(n) && t < 2000) begin
            tick;
            t++;
            if (rspValid === 1'b1) begin
                chk("rspData", e0 + st * k[15:0], rspData);
                chk("rspLast", {15'h0, k == int'(n) - 1}, {15'h0, rspLast});
                k++;
            end
        end
        if (k < int'(n)) begin
            n_mismatch++;
            $display("ERROR response wait expected %0d seen %0d", n, k);
            conclude;
        end
    endtask : rd

    task t_probe;
        rd(ADDR_BYTE_ORDER_PROBE, 5'd1, 1'b0, BYTE_ORDER_PATTERN, 16'h0);
        rd(ADDR_BYTE_ORDER_PROBE, 5'd1, 1'b1, {BYTE_ORDER_PATTERN[7:0],
           BYTE_ORDER_PATTERN[15:8]}, 16'h0);
        rd(9'h1ff, 5'd1, 1'b0, UNMAPPED_WORD, 16'h0);
        rd(ADDR_FABRIC_DATA, 5'd1, 1'b0, 16'h0, 16'h0);
        rd(ADDR_FABRIC_COMMAND, 5'd1, 1'b0, 16'h0, 16'h0);
        rd(ADDR_AUTONEG_EXPANSION, 5'd1, 1'b0, 16'h0, 16'h0);
        rd(ADDR_AUTONEG_EXPANSION, 5'd1, 1'b0, 16'h0, 16'h0);
        $display("t_probe done");
    endtask : t_probe

    task automatic t_status;
        int rp;
        int tp;
        rp = 0;
        tp = 0;
        rd(ADDR_RX_STATUS, 5'd1, 1'b0, 16'h5a01, 16'h0);
        repeat (10) begin
            tick;
            if (rxStatusPop === 1'b1) rp++;
        end
        rd(ADDR_TX_STATUS, 5'd1, 1'b0, 16'h6b02, 16'h0);
        repeat (10) begin
            tick;
            if (txStatusPop === 1'b1) tp++;
        end
        chk("rxStatusPop", 16'h1, rp[15:0]);
        chk("txStatusPop", 16'h1, tp[15:0]);
        rd(ADDR_TX_FIFO_LEVEL, 5'd1, 1'b0, 16'h1, 16'h0);
        $display("t_status done");
    endtask : t_status

    // Fill until refused, then drain in two bursts down to empty
    task automatic t_fifo;
        int   cnt;
        logic r;
        cnt = 0;
        rxWrValid = 1'b1;
        for (int i = 0; i < 20; i++) begin
            rxWrData = 16'ha000 + cnt[15:0];
            r = rxWrReady;
            tick;
            if (r) cnt++;
        end
        rxWrValid = 1'b0;
        chk("fifo words", 16'(RX_FIFO_DEPTH), cnt[15:0]);
        rd(ADDR_RX_DATA, 5'd5, 1'b0, 16'ha000, 16'h1);
        rd(ADDR_RX_FIFO_LEVEL, 5'd1, 1'b0, 16'h3, 16'h0);
        rd(ADDR_RX_DATA, 5'd3, 1'b0, 16'ha005, 16'h1);
        rd(ADDR_RX_DATA, 5'd1, 1'b0, 16'h0, 16'h0);
        rd(ADDR_RX_FIFO_LEVEL, 5'd1, 1'b0, 16'h0, 16'h0);
        $display("t_fifo done");
    endtask : t_fifo

    task t_drop;
        repeat (3) begin
            dropPulse = 1'b1;
            tick;
            dropPulse = 1'b0;
            tick;
        end
        rd(ADDR_DROP_COUNT, 5'd1, 1'b0, 16'h3, 16'h0);
        rd(ADDR_DROP_COUNT, 5'd1, 1'b0, 16'h0, 16'h0);
        $display("t_drop done");
    endtask : t_drop

    initial begin
        {srst, cmdValid, cmdSwap, rxWrValid, dropPulse} = 5'h10;
        {cmdAddr, cmdWords, rxWrData} = '0;
        {rxStatusValid, txStatusValid} = 2'h3;
        rxStatusWord = 16'h5a01;
        txStatusWord = 16'h6b02;
        n_mismatch = 0;
        compares = 0;
        repeat (10) @(posedge core_clk);
        #1 srst = 1'b0;
        t_probe;
        t_status;
        t_fifo;
        t_drop;
        conclude;
    end
endmodule : tb
`default_nettype wire
